// ===== logic/pdmc_params.svh
// Register offsets, field positions and reset values of the port data mux control
`ifndef PDMC_PARAMS_SVH
`define PDMC_PARAMS_SVH
`define PDMC_OFF_CTRL      12'h000
`define PDMC_OFF_ROUTE     12'h004
`define PDMC_OFF_XBAR      12'h008
`define PDMC_OFF_PULL      12'h00C
`define PDMC_OFF_CHG       12'h010
`define PDMC_OFF_STATUS    12'h014
`define PDMC_OFF_MASK      12'h018
`define PDMC_OFF_PINS      12'h01C
`define PDMC_CTRL_FLIP     0
`define PDMC_CTRL_EPTX     1
`define PDMC_CTRL_DCD      2
`define PDMC_CTRL_CMPEN_LO 8
`define PDMC_CTRL_XBAR_EN  16
`define PDMC_XBAR_RST      32'h0000_0000
`define PDMC_ROUTE_RST     32'h0000_0000
`define PDMC_PULL_RST      32'h0000_0000
`define PDMC_CHG_RST       32'h0000_0000
`define PDMC_MASK_RST      32'h0000_0000
`define PDMC_ENDPOINT_BPS  1500000
`endif

// ===== logic/pdmc_pkg.sv
// Types shared by the port data mux control
package pdmc_pkg;
    // Source picked for one pair by the first stage
    typedef enum logic [3:0] {
        PDMC_SRC_NONE  = 4'h0,
        PDMC_SRC_ROOT  = 4'h1,
        PDMC_SRC_EP    = 4'h2,
        PDMC_SRC_SWD   = 4'h3,
        PDMC_SRC_DBG12 = 4'h4,
        PDMC_SRC_DBG34 = 4'h5,
        PDMC_SRC_AUX   = 4'h6,
        PDMC_SRC_UART  = 4'h7,
        PDMC_SRC_LSX   = 4'h8
    } pdmc_src_t;
    // Crossbar lane sources: system pins and core channel receive lines
    typedef enum logic [2:0] {
        PDMC_XS_OFF    = 3'h0,
        PDMC_XS_SYS_RX = 3'h1,
        PDMC_XS_LSX_IN = 3'h2,
        PDMC_XS_GP1    = 3'h3,
        PDMC_XS_GP2    = 3'h4,
        PDMC_XS_CH_A   = 3'h5,
        PDMC_XS_CH_B   = 3'h6,
        PDMC_XS_CH_C   = 3'h7
    } pdmc_xsrc_t;
    typedef enum logic [1:0] {
        PDMC_AXI_IDLE = 2'b01,
        PDMC_AXI_RESP = 2'b10
    } pdmc_wr_t;
endpackage

// ===== logic/pdmc_top.sv
// Port data mux control: routing, crossbar, pulls, clamps, charger detect, AXI4-Lite slave
`timescale 1ns/1ps
`include "pdmc_params.svh"
// Functional notes
// [RULE_01] Reversed orientation swaps top and bottom D+/D- pair connections.
// [RULE_02] Sideband pair keeps listed order upside-up and swaps when reversed.
// [RULE_03] Root, endpoint, wire-debug, debug and aux pairs selectable; positive on first pin.
// [RULE_04] Core channel A top only, B bottom only, C sideband only; tx first pin.
// [RULE_05] Crossbar maps serial, lowspeed exchange and two general pins to any channel.
// [RULE_06] Each crossbar pin is configured as input or output by firmware.
// [RULE_07] At reset crossbar copies system serial receive onto system serial transmit.
// [RULE_08] Enabled comparators raise an interrupt on any port input switching event. Code latches a status flag; irq needs that pin's mask bit set too.
// [RULE_09] Firmware disables comparators on pins carrying analog voltages.
// [RULE_10] Pull-up and pull-down individually selectable for all six port outputs.
// [RULE_11] Clamp attached to a pin only while a second-stage path is closed.
// [RULE_12] Endpoint is low-speed 1.5 Mbps, endpoint zero only, billboard class.
// [RULE_13] Endpoint transmitter drives the pair selected by orientation.
// [RULE_14] Endpoint pull-up off while sending, else on orientation-chosen D- pin.
// [RULE_15] Contact detect applies D+ current and D- pulldown on oriented pair.
// [RULE_16] Twelve firmware switches force, sink or sense on any of four pins.
// [RULE_17] Serial and lowspeed exchange paths are buffered with tri-state control.
// [RULE_18] One registered orientation steers every orientation-dependent selection.
module pdmc_top #(
    parameter int NPORT = 6
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        orient_flip,
    input  wire logic [1:0]  root_port_in,
    input  wire logic [1:0]  endpoint_in,
    input  wire logic [1:0]  swd_in,
    input  wire logic [3:0]  dbg_in,
    input  wire logic [1:0]  aux_in,
    input  wire logic        endpoint_tx_active,
    input  wire logic [5:0]  port_in,
    output logic [5:0]       port_out,
    output logic [5:0]       port_oe,
    output logic [5:0]       port_pullup,
    output logic [5:0]       port_pulldown,
    output logic [5:0]       port_clamp,
    output logic [1:0]       endpoint_rx,
    output logic [1:0]       endpoint_pullup,
    output logic [1:0]       dplus_contact_current,
    output logic [1:0]       dminus_contact_pulldown,
    output logic [3:0]       detect_voltage_force,
    output logic [3:0]       detect_current_sink,
    output logic [3:0]       detect_sense,
    input  wire logic        sys_serial_rx,
    output logic             sys_serial_tx,
    output logic             sys_serial_tx_oe,
    input  wire logic        lowspeed_xchg_in,
    output logic             lowspeed_xchg_out,
    output logic             lowspeed_xchg_oe,
    input  wire logic        general_pin_one_i,
    output logic             general_pin_one_o,
    output logic             general_pin_one_oe,
    input  wire logic        general_pin_two_i,
    output logic             general_pin_two_o,
    output logic             general_pin_two_oe,
    output logic             irq
);
    import pdmc_pkg::*;

    // Port index: 0 top D+, 1 top D-, 2 bottom D+, 3 bottom D-, 4 sideband a, 5 sideband b
    logic [31:0] ctrl_ff, route_ff, xbar_ff, pull_ff, chg_ff, status_ff, mask_ff;
    logic [5:0]  port_d_ff;
    logic        flip_ff;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
        return r;
    endfunction

    // Pair source, packed as {neg,pos}; core channel lines come from crossbar
    function automatic logic [1:0] pick(input pdmc_src_t s, input logic [1:0] ch,
                                        input logic [1:0] lsx, input logic [1:0] rp,
                                        input logic [1:0] ep, input logic [1:0] sw,
                                        input logic [3:0] dg, input logic [1:0] ax);
        case (s)
            PDMC_SRC_ROOT:  return rp;
            PDMC_SRC_EP:    return ep;
            PDMC_SRC_SWD:   return sw;
            PDMC_SRC_DBG12: return dg[1:0];
            PDMC_SRC_DBG34: return dg[3:2];
            PDMC_SRC_AUX:   return ax;
            PDMC_SRC_UART:  return ch;
            PDMC_SRC_LSX:   return lsx;
            default:        return 2'b00;
        endcase
    endfunction

    // Orientation sampled once so every swap below moves together
    always_ff @(posedge aclk) begin
        if (!aresetn) flip_ff <= 1'b0;
        else          flip_ff <= orient_flip ^ ctrl_ff[`PDMC_CTRL_FLIP]; // RULE_18
    end

    // ---------------- AXI4-Lite slave ----------------
    logic        aw_ff, w_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        do_wr, do_rd;
    logic [31:0] rd_val;
    logic        rd_hit;

    assign s_axi_awready = !aw_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_wr = aw_ff && w_ff && !s_axi_bvalid;
    assign do_rd = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0; w_ff <= 1'b0; awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000; wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1; awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1; wdata_ff <= s_axi_wdata; wstrb_ff <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_ff <= 1'b0; w_ff <= 1'b0; s_axi_bvalid <= 1'b1;
                case ({2'b00, awaddr_ff[11:2]})
                    `PDMC_OFF_CTRL >> 2, `PDMC_OFF_ROUTE >> 2, `PDMC_OFF_XBAR >> 2,
                    `PDMC_OFF_PULL >> 2, `PDMC_OFF_CHG >> 2, `PDMC_OFF_MASK >> 2:
                        s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        case ({2'b00, s_axi_araddr[11:2]})
            `PDMC_OFF_CTRL >> 2:   rd_val = ctrl_ff;
            `PDMC_OFF_ROUTE >> 2:  rd_val = route_ff;
            `PDMC_OFF_XBAR >> 2:   rd_val = xbar_ff;
            `PDMC_OFF_PULL >> 2:   rd_val = pull_ff;
            `PDMC_OFF_CHG >> 2:    rd_val = chg_ff;
            `PDMC_OFF_STATUS >> 2: rd_val = status_ff;
            `PDMC_OFF_MASK >> 2:   rd_val = mask_ff;
            `PDMC_OFF_PINS >> 2:   rd_val = {25'h0000000, flip_ff, port_d_ff};
            default: begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0000_0000; s_axi_rresp <= 2'h0;
        end else if (do_rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    function automatic logic wr_to(input logic [11:0] a, input logic [11:0] off);
        return (a[11:2] == off[11:2]);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff  <= 32'h0000_0000;
            route_ff <= `PDMC_ROUTE_RST;
            xbar_ff  <= `PDMC_XBAR_RST; // RULE_07
            pull_ff  <= `PDMC_PULL_RST;
            chg_ff   <= `PDMC_CHG_RST;
            mask_ff  <= `PDMC_MASK_RST;
        end else if (do_wr) begin
            if (wr_to(awaddr_ff, `PDMC_OFF_CTRL))
                ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff);
            if (wr_to(awaddr_ff, `PDMC_OFF_ROUTE))
                route_ff <= merge(route_ff, wdata_ff, wstrb_ff);
            if (wr_to(awaddr_ff, `PDMC_OFF_XBAR))
                xbar_ff <= merge(xbar_ff, wdata_ff, wstrb_ff); // RULE_05
            if (wr_to(awaddr_ff, `PDMC_OFF_PULL))
                pull_ff <= merge(pull_ff, wdata_ff, wstrb_ff); // RULE_10
            if (wr_to(awaddr_ff, `PDMC_OFF_CHG))
                chg_ff <= merge(chg_ff, wdata_ff, wstrb_ff); // RULE_16
            if (wr_to(awaddr_ff, `PDMC_OFF_MASK))
                mask_ff <= merge(mask_ff, wdata_ff, wstrb_ff);
        end
    end

    // ---------------- Digital crossbar ----------------
    // Lanes: 0 sys tx, 1 lowspeed out, 2 gp1, 3 gp2, 4..6 channel a/b/c tx
    // xbar[3*i+:3] source of lane i; xbar[24+k] output enable of pin k
    logic [2:0] ch_rx;
    logic [6:0] lane;
    logic [7:0] xsrc;
    // Receive lines must follow the same swap as the transmit lines
    assign ch_rx = flip_ff ? {port_in[4], port_in[1], port_in[3]}
                           : {port_in[5], port_in[3], port_in[1]}; // RULE_04 RULE_18
    assign xsrc = {ch_rx, general_pin_two_i, general_pin_one_i, lowspeed_xchg_in,
                   sys_serial_rx, 1'b0};
    generate
        for (genvar i = 0; i < 7; i++) begin : g_lane
            assign lane[i] = xsrc[xbar_ff[3*i +: 3]]; // RULE_05
        end
    endgenerate

    logic xbar_live;
    assign xbar_live = ctrl_ff[`PDMC_CTRL_XBAR_EN];
    // Bypass until firmware takes over, so chained parts still pass code at boot
    assign sys_serial_tx      = xbar_live ? lane[0] : sys_serial_rx; // RULE_07
    assign sys_serial_tx_oe   = xbar_live ? xbar_ff[24] : 1'b1; // RULE_17
    assign lowspeed_xchg_out  = lane[1];
    assign lowspeed_xchg_oe   = xbar_live & xbar_ff[25]; // RULE_06 RULE_17
    assign general_pin_one_o  = lane[2];
    assign general_pin_one_oe = xbar_live & xbar_ff[26]; // RULE_06
    assign general_pin_two_o  = lane[3];
    assign general_pin_two_oe = xbar_live & xbar_ff[27]; // RULE_06

    // ---------------- Port data mux ----------------
    // route: [3:0] top pair source, [7:4] bottom, [11:8] sideband
    pdmc_src_t sel_top, sel_bot, sel_sbu, sel_a, sel_b;
    logic [1:0] drv_top, drv_bot, drv_sbu, drv_a, drv_b;
    logic [1:0] lsx_pair;
    assign sel_top  = pdmc_src_t'(route_ff[3:0]);
    assign sel_bot  = pdmc_src_t'(route_ff[7:4]);
    assign sel_sbu  = pdmc_src_t'(route_ff[11:8]);
    assign lsx_pair = {1'b0, lane[1]};
    // Reversed cable: pair A feeds bottom pins and B feeds top
    assign sel_a = flip_ff ? sel_bot : sel_top; // RULE_01 RULE_13
    assign sel_b = flip_ff ? sel_top : sel_bot; // RULE_01
    assign drv_a = pick(sel_top, {1'b0, lane[4]}, 2'b00, root_port_in, endpoint_in,
                        swd_in, dbg_in, aux_in); // RULE_03 RULE_04
    assign drv_b = pick(sel_bot, {1'b0, lane[5]}, 2'b00, root_port_in, endpoint_in,
                        swd_in, dbg_in, aux_in); // RULE_03 RULE_04
    assign drv_top = flip_ff ? drv_b : drv_a; // RULE_01
    assign drv_bot = flip_ff ? drv_a : drv_b; // RULE_01
    // Root port and endpoint never reach the sideband pins
    assign drv_sbu = pick(sel_sbu, {1'b0, lane[6]}, lsx_pair, 2'b00, 2'b00,
                          swd_in, dbg_in, aux_in); // RULE_03 RULE_04

    logic [5:0] path_closed;
    logic top_on, bot_on, sbu_on;
    assign top_on = (sel_a != PDMC_SRC_NONE);
    assign bot_on = (sel_b != PDMC_SRC_NONE);
    assign sbu_on = (sel_sbu != PDMC_SRC_NONE) && (sel_sbu != PDMC_SRC_ROOT)
                    && (sel_sbu != PDMC_SRC_EP);
    assign path_closed = {{2{sbu_on}}, {2{bot_on}}, {2{top_on}}};

    // Core channel receive pins are inputs, so only tx member is driven
    function automatic logic [1:0] pair_oe(input pdmc_src_t s);
        return (s == PDMC_SRC_UART || s == PDMC_SRC_LSX) ? 2'b01 :
               (s == PDMC_SRC_NONE) ? 2'b00 : 2'b11;
    endfunction

    logic [1:0] sbu_oe;
    assign sbu_oe = pair_oe(sel_sbu) & {2{sbu_on}};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_out <= 6'h00;
            port_oe  <= 6'h00;
        end else begin
            port_out[1:0] <= drv_top;
            port_out[3:2] <= drv_bot;
            // Sideband pins swap with orientation
            port_out[5:4] <= flip_ff ? {drv_sbu[0], drv_sbu[1]} : drv_sbu; // RULE_02
            port_oe[1:0]  <= pair_oe(sel_a);
            port_oe[3:2]  <= pair_oe(sel_b);
            port_oe[5:4]  <= flip_ff ? {sbu_oe[0], sbu_oe[1]} : sbu_oe; // RULE_02
        end
    end

    // Endpoint receive follows the oriented pair carrying it
    assign endpoint_rx = (sel_top == PDMC_SRC_EP) ? (flip_ff ? port_in[3:2] : port_in[1:0])
                       : (sel_bot == PDMC_SRC_EP) ? (flip_ff ? port_in[1:0] : port_in[3:2])
                       : 2'b00; // RULE_13

    // ---------------- Pulls, clamps, endpoint, charger ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_pullup             <= 6'h00;
            port_pulldown           <= 6'h00;
            port_clamp              <= 6'h00;
            endpoint_pullup         <= 2'b00;
            dplus_contact_current   <= 2'b00;
            dminus_contact_pulldown <= 2'b00;
            detect_voltage_force    <= 4'h0;
            detect_current_sink     <= 4'h0;
            detect_sense            <= 4'h0;
        end else begin
            port_pullup   <= pull_ff[5:0]; // RULE_10
            port_pulldown <= pull_ff[13:8]; // RULE_10
            port_clamp    <= path_closed; // RULE_11
            // Low-speed advertised on D- of the oriented pair, dropped while sending
            endpoint_pullup <= endpoint_tx_active ? 2'b00 :
                               (flip_ff ? 2'b10 : 2'b01); // RULE_12 RULE_14
            dplus_contact_current   <= ctrl_ff[`PDMC_CTRL_DCD] ?
                                       (flip_ff ? 2'b10 : 2'b01) : 2'b00; // RULE_15
            dminus_contact_pulldown <= ctrl_ff[`PDMC_CTRL_DCD] ?
                                       (flip_ff ? 2'b10 : 2'b01) : 2'b00; // RULE_15
            detect_voltage_force    <= chg_ff[3:0]; // RULE_16
            detect_current_sink     <= chg_ff[7:4]; // RULE_16
            detect_sense            <= chg_ff[11:8]; // RULE_16
        end
    end

    // ---------------- Comparators and interrupt ----------------
    logic [5:0] cmp_en, edge_evt;
    assign cmp_en = ctrl_ff[`PDMC_CTRL_CMPEN_LO +: 6]; // RULE_09
    assign edge_evt = (port_in ^ port_d_ff) & cmp_en; // RULE_08
    always_ff @(posedge aclk) begin
        if (!aresetn) port_d_ff <= 6'h00;
        else          port_d_ff <= port_in;
    end
    // A read clears the flags, but an edge in the same cycle still lands
    always_ff @(posedge aclk) begin
        if (!aresetn)
            status_ff <= 32'h0000_0000;
        else if (do_rd && wr_to(s_axi_araddr, `PDMC_OFF_STATUS))
            status_ff <= {26'h0000000, edge_evt}; // RULE_08
        else
            status_ff <= status_ff | {26'h0000000, edge_evt}; // RULE_08
    end
    assign irq = |(status_ff & mask_ff); // RULE_08

    a_bypass_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        !xbar_live |-> (sys_serial_tx == sys_serial_rx) && sys_serial_tx_oe)
        else $error("bypass not active"); // RULE_07
    a_clamp_path: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 port_clamp == $past(path_closed)) else $error("clamp mismatch"); // RULE_11
    a_pullup_tx: assert property (@(posedge aclk) disable iff (!aresetn)
        endpoint_tx_active |=> endpoint_pullup == 2'b00) else $error("pullup on tx"); // RULE_14
    a_pullup_side: assert property (@(posedge aclk) disable iff (!aresetn)
        !endpoint_tx_active && flip_ff |=> endpoint_pullup == 2'b10)
        else $error("pullup side"); // RULE_14
    a_dcd_side: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_ff[`PDMC_CTRL_DCD] && !flip_ff |=> dplus_contact_current == 2'b01)
        else $error("dcd side"); // RULE_15
    a_edge_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        |edge_evt |=> |status_ff[5:0]) else $error("event lost"); // RULE_08
    a_pair_swap: assert property (@(posedge aclk) disable iff (!aresetn)
        flip_ff && $stable(flip_ff) |=> port_out[3:2] == $past(drv_a))
        else $error("pair not swapped"); // RULE_01
    a_sbu_swap: assert property (@(posedge aclk) disable iff (!aresetn)
        flip_ff |=> port_out[5:4] == {$past(drv_sbu[0]), $past(drv_sbu[1])})
        else $error("sideband not swapped"); // RULE_02
    a_chg_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> detect_sense == $past(chg_ff[11:8])) else $error("charger switch"); // RULE_16
    a_gp_oe_boot: assert property (@(posedge aclk) disable iff (!aresetn)
        !xbar_live |-> !general_pin_one_oe && !lowspeed_xchg_oe)
        else $error("pin driven at boot"); // RULE_06
endmodule // pdmc_top

// ===== verif/pdmc_port_partner.sv
// Far-side port model: echoes driven pins, shows bench levels on released pins
`timescale 1ns/1ps
module pdmc_port_partner (
    input  wire logic [5:0] port_out,
    input  wire logic [5:0] port_oe,
    input  wire logic [5:0] ext,
    output logic      [5:0] port_in
);
    // A released pin carries the far side's own level, never the last driven one
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            port_in[i] = port_oe[i] ? port_out[i] : ext[i];
        end
    end
endmodule // pdmc_port_partner

// ===== verif/pdmc_top_tb.sv
// Self-checking bench of the port data mux control
`timescale 1ns/1ps
`include "pdmc_params.svh"
module pdmc_top_tb;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, orient_flip = 0, endpoint_tx_active = 0;
    logic sys_serial_rx = 0, lowspeed_xchg_in = 0, general_pin_one_i = 0, general_pin_two_i = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, dbg_in = 4'h5;
    logic [1:0] root_port_in = 2'h2, endpoint_in = 2'h1, swd_in = 2'h2, aux_in = 2'h1;
    logic [5:0] ext = 6'h0, port_in, port_out, port_oe, port_pullup, port_pulldown, port_clamp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic sys_serial_tx, sys_serial_tx_oe, lowspeed_xchg_out, lowspeed_xchg_oe;
    logic general_pin_one_o, general_pin_one_oe, general_pin_two_o, general_pin_two_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp, endpoint_rx, endpoint_pullup;
    logic [1:0] dplus_contact_current, dminus_contact_pulldown, r;
    logic [3:0] detect_voltage_force, detect_current_sink, detect_sense;
    logic [31:0] d;
    int n_fail = 0, comparisons = 0;
    always #2 aclk = ~aclk;
    pdmc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .orient_flip, .root_port_in, .endpoint_in, .swd_in,
        .dbg_in, .aux_in, .endpoint_tx_active, .port_in, .port_out, .port_oe, .port_pullup,
        .port_pulldown, .port_clamp, .endpoint_rx, .endpoint_pullup, .dplus_contact_current,
        .dminus_contact_pulldown, .detect_voltage_force, .detect_current_sink, .detect_sense,
        .sys_serial_rx, .sys_serial_tx, .sys_serial_tx_oe, .lowspeed_xchg_in,
        .lowspeed_xchg_out, .lowspeed_xchg_oe, .general_pin_one_i, .general_pin_one_o,
        .general_pin_one_oe, .general_pin_two_i, .general_pin_two_o, .general_pin_two_oe, .irq);
    pdmc_port_partner far_end (.port_out(port_out), .port_oe(port_oe), .ext(ext),
        .port_in(port_in));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    // Ready is sampled mid-cycle; valid is only dropped after the edge that takes it
    task axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rsp);
        logic ta, tw, da, dw, b;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        s_axi_bready <= 1; da = 0; dw = 0; b = 0;
        while (!(da && dw)) begin
            @(negedge aclk); ta = s_axi_awready && s_axi_awvalid; tw = s_axi_wready && s_axi_wvalid;
            @(posedge aclk);
            if (ta) begin s_axi_awvalid <= 0; da = 1; end
            if (tw) begin s_axi_wvalid <= 0; dw = 1; end
        end
        while (!b) begin
            @(negedge aclk); b = s_axi_bvalid; rsp = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 0;
    endtask
    task axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
        logic t;
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1; t = 0;
        while (!t) begin
            @(negedge aclk); t = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 0; t = 0;
        while (!t) begin
            @(negedge aclk); t = s_axi_rvalid; v = s_axi_rdata; rsp = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 0;
    endtask
    task t_bypass;
        repeat (5) begin
            @(posedge aclk); sys_serial_rx <= ~sys_serial_rx;
            @(negedge aclk); chk(sys_serial_tx, sys_serial_rx);
            chk({sys_serial_tx_oe, sys_serial_tx}, {1'b1, sys_serial_rx});
        end
        @(posedge aclk); aresetn <= 1;
        $display("test bypass done");
    endtask
    task t_irq;
        axw(`PDMC_OFF_CTRL, 32'h0000_0100, r);
        axw(`PDMC_OFF_MASK, 32'h0000_0001, r);
        settle(1); chk(port_clamp, 6'h00);
        @(posedge aclk); ext[0] <= 1;
        settle(3); chk(irq, 1'b1);
        axr(`PDMC_OFF_STATUS, d, r); chk(d[5:0], 6'h01);
        settle(1); chk(irq, 1'b0);
        axw(`PDMC_OFF_MASK, 32'h0, r);
        @(posedge aclk); ext[0] <= 0;
        settle(3); chk(irq, 1'b0);
        axr(`PDMC_OFF_STATUS, d, r); chk(d[5:0], 6'h01);
        $display("test irq done");
    endtask
    task t_route;
        axw(`PDMC_OFF_ROUTE, 32'h0000_0321, r); chk(r, 2'h0);
        axw(`PDMC_OFF_PULL, 32'h0000_2A15, r);
        settle(3); chk(port_out, 6'h26);
        chk({port_oe, port_clamp}, 12'hFFF);
        chk({port_pullup, port_pulldown}, {6'h15, 6'h2A});
        chk(endpoint_rx, 2'h1);
        @(posedge aclk); orient_flip <= 1;
        settle(3); chk(port_out, 6'h19);
        chk(endpoint_rx, 2'h1);
        axr(12'h020, d, r); chk({r, d}, {2'h2, 32'h0});
        axw(`PDMC_OFF_STATUS, 32'h0, r); chk(r, 2'h2);
        $display("test route done");
    endtask
    task t_endpoint;
        chk(endpoint_pullup, 2'h2);
        @(posedge aclk); orient_flip <= 0;
        settle(3); chk(endpoint_pullup, 2'h1);
        axw(`PDMC_OFF_CTRL, 32'h0000_0004, r);
        settle(3); chk({dplus_contact_current, dminus_contact_pulldown}, 4'h5);
        @(posedge aclk); orient_flip <= 1;
        settle(3); chk({dplus_contact_current, dminus_contact_pulldown}, 4'hA);
        @(posedge aclk); endpoint_tx_active <= 1;
        settle(3); chk(endpoint_pullup, 2'h0);
        $display("test endpoint done");
    endtask
    task t_xbar;
        axw(`PDMC_OFF_XBAR, 32'h0B05_4A0B, r);
        axw(`PDMC_OFF_ROUTE, 32'h0000_0777, r);
        axw(`PDMC_OFF_CHG, 32'h0000_0A53, r);
        chk(r, 2'h0);
        @(posedge aclk);
        sys_serial_rx <= 1;
        general_pin_one_i <= 0;
        general_pin_two_i <= 1;
        lowspeed_xchg_in <= 0;
        ext <= 6'h08;
        axw(`PDMC_OFF_CTRL, 32'h0001_0000, r);
        settle(3);
        chk({sys_serial_tx_oe, sys_serial_tx, lowspeed_xchg_oe, lowspeed_xchg_out},
            4'hB);
        chk({general_pin_one_oe, general_pin_one_o, general_pin_two_oe, general_pin_two_o},
            4'h3);
        chk(port_out, 6'h24);
        chk(port_oe, 6'h25);
        chk({detect_sense, detect_current_sink, detect_voltage_force}, 12'hA53);
        axw(`PDMC_OFF_ROUTE, 32'h0000_0854, r);
        settle(3);
        chk({port_out, port_oe}, 12'h96F);
        @(posedge aclk);
        aresetn <= 0;
        settle(2);
        chk({sys_serial_tx_oe, sys_serial_tx, port_oe}, {2'h3, 6'h00});
        @(posedge aclk);
        aresetn <= 1;
        settle(2);
        chk({port_oe, port_clamp, general_pin_two_oe}, 13'h0000);
        $display("test xbar done");
    endtask
    task test_done;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Whole run is about a hundred and ten cycles; this limit only cuts a hung handshake
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        test_done();
    end
    initial begin
        t_bypass();
        t_irq();
        t_route();
        t_endpoint();
        t_xbar();
        test_done();
    end
endmodule // pdmc_top_tb
